// >>> design/spss_status.sv
// Socket presence status register with pin sampling and event flags
`timescale 1ns/1ps
module spss_status (
    // Clock and resets
    input wire logic mclk,
    input wire logic resetn,
    input wire logic global_reset,
    input wire logic pci_bus_reset,
    input wire logic pme_enable,
    // Register read
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    output logic [31:0] rd_data,
    // Force-event write path
    input wire logic force_wr,
    input wire logic [31:0] force_data,
    // Card pins
    input wire logic card_detect_pin_a,
    input wire logic card_detect_pin_b,
    input wire logic card_status_change_pin,
    input wire logic card_ready_irq_pin,
    // Interrogation and power logic
    input wire logic ident_busy,
    input wire logic ident_done,
    input wire spss_pkg::spss_ident_s ident_result,
    input wire logic power_ack,
    input wire logic power_on,
    input wire logic invalid_req,
    input wire logic data_loss_evt,
    input wire logic [7:0] dev_ctrl_cfg,
    // Outputs to neighbours
    output spss_pkg::spss_evt_s evt_set,
    output logic retest_req,
    output logic power_ctl_enable
);
    logic [3:0] s1_q, s1_d, s2_q, s2_d;
    logic [3:0] pin_d;
    logic cda_q, cda_d, cdb_q, cdb_d, sts_q, sts_d, rdy_q, rdy_d;
    logic sts_prev_q, sts_prev_d;
    logic [1:0] sock_lo_q, sock_lo_d;
    logic sock_3v3_q, sock_3v3_d;
    logic [3:0] volts_q, volts_d;
    logic wide_q, wide_d, narrow_q, narrow_d, unrec_q, unrec_d;
    logic bad_q, bad_d, loss_q, loss_d, pwr_q, pwr_d;
    logic [31:0] rd_q, rd_d;
    spss_pkg::spss_evt_s evt_q, evt_d;
    logic retest_q, retest_d, pce_q, pce_d;
    spss_pkg::spss_state_e st_q, st_d;
    logic ctx_clr;
    logic [31:0] img;

    assign pin_d = {card_ready_irq_pin, card_status_change_pin,
                    card_detect_pin_b, card_detect_pin_a};

    // Two-stage sampling; only the second stage is read
    always_comb begin
        s1_d = pin_d;
        s2_d = s1_q;
    end

    // Start at the empty-socket levels so reset gives no false edge
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s1_q <= spss_pkg::SPSS_PIN_IDLE;
            s2_q <= spss_pkg::SPSS_PIN_IDLE;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
        end
    end

    // Context bits survive a bus reset only while events are enabled
    assign ctx_clr = global_reset || (pci_bus_reset && !pme_enable);

    // Interrogation is tracked so the detect bits can be frozen meanwhile
    always_comb begin
        st_d = st_q;
        case (st_q)
            spss_pkg::SPSS_IDLE: begin
                if (ident_busy) begin
                    st_d = spss_pkg::SPSS_IDENT;
                end
            end
            spss_pkg::SPSS_IDENT: begin
                if (ident_done) begin
                    st_d = spss_pkg::SPSS_LOAD;
                end
            end
            spss_pkg::SPSS_LOAD: begin
                st_d = spss_pkg::SPSS_IDLE;
            end
            default: begin
                st_d = spss_pkg::SPSS_IDLE;
            end
        endcase
    end

    always_comb begin
        cda_d = cda_q;
        cdb_d = cdb_q;
        sts_d = s2_q[2];
        rdy_d = s2_q[3];
        sts_prev_d = sts_q;
        sock_lo_d = sock_lo_q;
        sock_3v3_d = sock_3v3_q;
        volts_d = volts_q;
        wide_d = wide_q;
        narrow_d = narrow_q;
        unrec_d = unrec_q;
        bad_d = bad_q;
        loss_d = loss_q;
        pwr_d = pwr_q;
        evt_d = '0;
        retest_d = 1'b0;
        pce_d = pce_q;
        // Detect pins are used by interrogation; hold the last level
        if (st_q == spss_pkg::SPSS_IDLE && !ident_busy) begin
            cda_d = s2_q[0];
            cdb_d = s2_q[1];
        end
        if (invalid_req) begin
            bad_d = 1'b1;
        end
        if (data_loss_evt) begin
            loss_d = 1'b1;
        end
        if (power_ack) begin
            pwr_d = power_on;
        end
        // Identification fields load from the result only when interrogation finishes
        if (st_q == spss_pkg::SPSS_IDENT && ident_done) begin
            volts_d = ident_result.volts;
            wide_d = ident_result.wide;
            narrow_d = ident_result.narrow;
            // A bad card stays flagged until a good one is identified
            if (ident_result.unrec || unrec_q) begin
                unrec_d = ident_result.unrec;
            end
        end
        // Change events from the live bits
        // Edge kind follows the card type held in narrow_q, set by the last interrogation or forced write
        evt_d.cda = cda_d != cda_q;
        evt_d.cdb = cdb_d != cdb_q;
        evt_d.pwr = pwr_d != pwr_q;
        evt_d.sts = narrow_q ? (sts_q != sts_prev_q)
                             : (sts_q && !sts_prev_q);
        if (force_wr) begin
            sock_lo_d = force_data[spss_pkg::SPSS_B_YY_SOCK:
                                   spss_pkg::SPSS_B_XX_SOCK];
            sock_3v3_d = force_data[spss_pkg::SPSS_B_3V3_SOCK];
            volts_d = volts_d | force_data[13:10];
            // A hardware event in the same cycle as the write wins
            bad_d = invalid_req |
                    force_data[spss_pkg::SPSS_B_BADREQ];
            loss_d = data_loss_evt |
                     force_data[spss_pkg::SPSS_B_LOSS];
            unrec_d = force_data[spss_pkg::SPSS_B_UNREC];
            wide_d = force_data[spss_pkg::SPSS_B_WIDE];
            narrow_d = force_data[spss_pkg::SPSS_B_NARROW];
            // Forced events touch only the flags, never the live bits
            evt_d.pwr = evt_d.pwr | force_data[spss_pkg::SPSS_B_PWR];
            evt_d.cdb = evt_d.cdb | force_data[spss_pkg::SPSS_B_CDB];
            evt_d.cda = evt_d.cda | force_data[spss_pkg::SPSS_B_CDA];
            evt_d.sts = evt_d.sts | force_data[spss_pkg::SPSS_B_STS];
            // Forced card voltages hold socket power off until a retest
            if (|force_data[13:10]) begin
                pce_d = 1'b0;
            end
            if (force_data[spss_pkg::SPSS_B_RETEST]) begin
                retest_d = 1'b1;
                pce_d = 1'b1;
            end
        end
        // A context clear outranks every set in the same cycle except those of the socket bits, status and ready levels, events, retest and power control
        if (ctx_clr) begin
            volts_d = 4'h0;
            wide_d = 1'b0;
            narrow_d = 1'b0;
            unrec_d = 1'b0;
            bad_d = 1'b0;
            loss_d = 1'b0;
            pwr_d = 1'b0;
            cda_d = 1'b0;
            cdb_d = 1'b0;
        end
    end

    always_comb begin
        img = '0;
        img[31:30] = sock_lo_q;
        img[29] = sock_3v3_q;
        // Config byte is read live, so no stale copy can linger
        img[28] = !dev_ctrl_cfg[spss_pkg::SPSS_CFG_5V_OVR];
        img[13:10] = volts_q;
        img[9] = bad_q;
        img[8] = loss_q;
        img[7] = unrec_q;
        img[6] = rdy_q;
        img[5] = wide_q;
        img[4] = narrow_q;
        img[3] = pwr_q;
        img[2] = cdb_q;
        img[1] = cda_q;
        img[0] = sts_q;
        rd_d = rd_q;
        // Read data is registered: answer one cycle after rd_en
        if (rd_en) begin
            rd_d = (rd_addr == spss_pkg::SPSS_OFF_STATUS) ? img : '0;
        end
    end

    // Read data moves only on a read, so a slow reader sees one word
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rd_q <= 32'h0000_0000;
        end else begin
            rd_q <= rd_d;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_q <= spss_pkg::SPSS_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // Live levels reset to the empty-socket level, like the sampler
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cda_q <= spss_pkg::SPSS_PIN_IDLE[0];
            cdb_q <= spss_pkg::SPSS_PIN_IDLE[1];
            sts_q <= spss_pkg::SPSS_PIN_IDLE[2];
            rdy_q <= spss_pkg::SPSS_PIN_IDLE[3];
            sts_prev_q <= spss_pkg::SPSS_PIN_IDLE[2];
            sock_lo_q <= spss_pkg::SPSS_STATUS_RST[31:30];
            sock_3v3_q <= spss_pkg::SPSS_STATUS_RST[29];
            volts_q <= 4'h0;
            wide_q <= 1'b0;
            narrow_q <= 1'b0;
            unrec_q <= 1'b0;
            bad_q <= 1'b0;
            loss_q <= 1'b0;
            pwr_q <= 1'b0;
        end else begin
            cda_q <= cda_d;
            cdb_q <= cdb_d;
            sts_q <= sts_d;
            rdy_q <= rdy_d;
            sts_prev_q <= sts_prev_d;
            sock_lo_q <= sock_lo_d;
            sock_3v3_q <= sock_3v3_d;
            volts_q <= volts_d;
            wide_q <= wide_d;
            narrow_q <= narrow_d;
            unrec_q <= unrec_d;
            bad_q <= bad_d;
            loss_q <= loss_d;
            pwr_q <= pwr_d;
        end
    end

    // Power control starts enabled; only forced card voltages drop it
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            evt_q <= '0;
            retest_q <= 1'b0;
            pce_q <= 1'b1;
        end else begin
            evt_q <= evt_d;
            retest_q <= retest_d;
            pce_q <= pce_d;
        end
    end

    assign rd_data = rd_q;
    assign evt_set = evt_q;
    assign retest_req = retest_q;
    assign power_ctl_enable = pce_q;
endmodule : spss_status

// >>> design/spss_pkg.sv
// Package: offsets, field positions and reset values of the socket status block
package spss_pkg;
    localparam logic [7:0] SPSS_OFF_STATUS = 8'h08;
    localparam logic [7:0] SPSS_OFF_FORCE = 8'h0C;
    localparam logic [31:0] SPSS_STATUS_RST = 32'h3000_0000;
    localparam int SPSS_B_YY_SOCK = 31;
    localparam int SPSS_B_XX_SOCK = 30;
    localparam int SPSS_B_3V3_SOCK = 29;
    localparam int SPSS_B_5V_SOCK = 28;
    localparam int SPSS_B_RETEST = 14;
    localparam int SPSS_B_BADREQ = 9;
    localparam int SPSS_B_LOSS = 8;
    localparam int SPSS_B_UNREC = 7;
    localparam int SPSS_B_WIDE = 5;
    localparam int SPSS_B_NARROW = 4;
    localparam int SPSS_B_PWR = 3;
    localparam int SPSS_B_CDB = 2;
    localparam int SPSS_B_CDA = 1;
    localparam int SPSS_B_STS = 0;
    localparam int SPSS_CFG_5V_OVR = 6;
    // Empty-socket pin levels {ready, status, detect b, detect a}
    localparam logic [3:0] SPSS_PIN_IDLE = 4'h3;

    // Identification result from the card interrogation logic
    typedef struct packed {
        logic [3:0] volts;
        logic wide;
        logic narrow;
        logic unrec;
    } spss_ident_s;

    // Event flags handed to the event register
    typedef struct packed {
        logic pwr;
        logic cdb;
        logic cda;
        logic sts;
    } spss_evt_s;

    typedef enum logic [1:0] {
        SPSS_IDLE = 2'b00,
        SPSS_IDENT = 2'b01,
        SPSS_LOAD = 2'b11
    } spss_state_e;
endpackage : spss_pkg

// >>> verif/spss_status_asserts.sv
// Assertion checker for the socket status block
`timescale 1ns/1ps
module spss_status_chk (
    // Clock, resets
    input wire logic mclk,
    input wire logic resetn,
    input wire logic global_reset,
    input wire logic pci_bus_reset,
    input wire logic pme_enable,
    // Register access
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic force_wr,
    input wire logic [31:0] force_data,
    input wire logic [7:0] dev_ctrl_cfg,
    // Outputs
    input wire spss_pkg::spss_evt_s evt_set,
    input wire logic retest_req,
    input wire logic power_ctl_enable
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Context clear wins over forced fields other than the socket bits in the same cycle, not over forced events, retest or power control
    wire clr = global_reset | (pci_bus_reset & ~pme_enable);
    wire rd8 = rd_en && rd_addr == spss_pkg::SPSS_OFF_STATUS;
    wire fw = force_wr && !clr;
    a_rsvd_zero: assert property (rd8 |=> rd_data[27:14] == 14'h0)
        else $error("reserved bits not zero");
    a_unmapped_zero: assert property (rd_en && !rd8 |=> rd_data == 32'h0)
        else $error("unmapped read not zero");
    a_data_hold: assert property (!rd_en |=> $stable(rd_data))
        else $error("read data moved");
    a_five_volt_off: assert property (rd8 && dev_ctrl_cfg[6] |=> !rd_data[28])
        else $error("bit 28 not cleared");
    a_force_evt: assert property (fw && force_data[0] |=> evt_set.sts)
        else $error("forced event missing");
    a_retest_pulse: assert property (fw && force_data[14] |=> retest_req)
        else $error("retest missing");
    a_retest_cause: assert property (retest_req |-> $past(force_wr))
        else $error("retest without write");
    a_power_drop: assert property (fw && |force_data[13:10]
        && !force_data[14] |=> !power_ctl_enable) else $error("power kept");
    a_power_back: assert property (fw && force_data[14]
        && force_data[13:10] == 4'h0 |=> power_ctl_enable) else $error("no power");
    c_retest: cover property (fw && force_data[14]);
    c_cfg: cover property (rd8 && dev_ctrl_cfg[6]);
    c_evt: cover property (evt_set.sts);
endmodule : spss_status_chk
bind spss_status spss_status_chk chk_u (.mclk(mclk), .resetn(resetn),
    .global_reset(global_reset), .pci_bus_reset(pci_bus_reset),
    .pme_enable(pme_enable), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data(rd_data), .force_wr(force_wr), .force_data(force_data),
    .dev_ctrl_cfg(dev_ctrl_cfg), .evt_set(evt_set),
    .retest_req(retest_req), .power_ctl_enable(power_ctl_enable));

// >>> verif/spss_card_model.sv
// Card in the socket: drives the card pins
`timescale 1ns/1ps
module spss_card_model (
    // Card state
    input wire logic present,
    input wire logic sts_lvl,
    input wire logic rdy_lvl,
    // Socket pins
    output logic cd_a,
    output logic cd_b,
    output logic sts_pin,
    output logic rdy_pin
);
    // Detect pins are pulled up; a card grounds both
    assign cd_a = ~present;
    assign cd_b = ~present;
    // Empty socket leaves signal pins at their pull-down level
    assign sts_pin = present & sts_lvl;
    assign rdy_pin = present & rdy_lvl;
endmodule : spss_card_model

// >>> verif/spss_status_tb.sv
// Self-checking bench for the socket status block
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin \
    failures++; $display("FAIL %0t got %h exp %h", $time, a, e); end end
module spss_status_tb;
    logic mclk, resetn, gr, pr, pme, rd_en, fw, busy, done, pack, pon;
    logic inv, loss, present, sts_l, rdy_l, cda, cdb, stsp, rdyp, rt, pce;
    logic [7:0] addr, cfg;
    logic [31:0] fd, rdata;
    spss_pkg::spss_ident_s res;
    spss_pkg::spss_evt_s evt;
    int failures = 0, num_checks = 0, sts_n = 0, rt_n = 0;
    int pwr_n = 0, cd_n = 0;
    spss_card_model card_u (.present(present), .sts_lvl(sts_l),
        .rdy_lvl(rdy_l), .cd_a(cda), .cd_b(cdb), .sts_pin(stsp), .rdy_pin(rdyp));
    spss_status dut_u (.mclk(mclk), .resetn(resetn), .global_reset(gr),
        .pci_bus_reset(pr), .pme_enable(pme), .rd_en(rd_en), .rd_addr(addr),
        .rd_data(rdata), .force_wr(fw), .force_data(fd),
        .card_detect_pin_a(cda), .card_detect_pin_b(cdb),
        .card_status_change_pin(stsp), .card_ready_irq_pin(rdyp),
        .ident_busy(busy), .ident_done(done), .ident_result(res),
        .power_ack(pack), .power_on(pon), .invalid_req(inv),
        .data_loss_evt(loss), .dev_ctrl_cfg(cfg), .evt_set(evt),
        .retest_req(rt), .power_ctl_enable(pce));
    initial begin
        mclk = 0;
        forever #25 mclk = ~mclk;
    end
    // Pulses last one cycle, so count them as they pass
    always @(posedge mclk) begin
        if (evt.sts === 1'b1) sts_n++;
        if (rt === 1'b1) rt_n++;
        if (evt.pwr === 1'b1) pwr_n++;
        if (evt.cda === 1'b1) cd_n++;
        if (evt.cdb === 1'b1) cd_n++;
    end
    task cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc
    task rd(input logic [7:0] a, input logic [31:0] e);
        rd_en = 1; addr = a; cyc(1); rd_en = 0;
        `CHK(rdata, e)
    endtask : rd
    task fc(input logic [31:0] d);
        fd = d; fw = 1; cyc(1); fw = 0;
    endtask : fc
    task t_reset;
        cfg = 8'h40; cyc(4);
        rd(8'h08, 32'h2000_0006);
        cfg = 8'h00;
        rd(8'h08, 32'h3000_0006);
        rd(8'h0C, 32'h0000_0000);
    endtask : t_reset
    task t_insert;
        busy = 1; cyc(1); present = 1; cyc(5);
        rd(8'h08, 32'h3000_0006);
        res = 7'h14; done = 1; cyc(1); done = 0; busy = 0;
        res = 7'h7B; cyc(4);
        rd(8'h08, 32'h3000_0820);
    endtask : t_insert
    task t_pins;
        sts_l = 1; rdy_l = 1; cyc(5);
        `CHK(sts_n, 1)
        rd(8'h08, 32'h3000_0861);
        sts_l = 0; cyc(5);
        `CHK(sts_n, 1)
        fc(32'h2000_0021); cyc(2);
        `CHK(sts_n, 2)
        rd(8'h08, 32'h3000_0860);
    endtask : t_pins
    task t_force;
        fc(32'hA000_2020);
        `CHK(pce, 1'b0)
        rd(8'h08, 32'hB000_2860);
        fc(32'h2000_4020);
        `CHK(pce, 1'b1)
        `CHK(rt, 1'b1)
        rd(8'h08, 32'h3000_2860);
        `CHK(rt_n, 1)
    endtask : t_force
    task t_context;
        pon = 1; pack = 1; inv = 1; loss = 1; cyc(1);
        pack = 0; inv = 0; loss = 0; cyc(1);
        rd(8'h08, 32'h3000_2B68);
        pme = 1; pr = 1; cyc(1); pr = 0; cyc(1);
        rd(8'h08, 32'h3000_2B68);
        gr = 1; cyc(1); gr = 0; cyc(4);
        rd(8'h08, 32'h3000_0040);
        pme = 0; pack = 1; cyc(1); pack = 0; pr = 1; cyc(1); pr = 0; cyc(4);
        rd(8'h08, 32'h3000_0040);
        fc(32'h2000_000E); cyc(2);
        `CHK(pwr_n, 3)
        `CHK(cd_n, 4)
        rd(8'h08, 32'h3000_0040);
    endtask : t_context
    task ident(input spss_pkg::spss_ident_s r);
        busy = 1; cyc(1); res = r; done = 1; cyc(1);
        done = 0; busy = 0; cyc(3);
    endtask : ident
    task t_narrow;
        inv = 1; fc(32'h2000_0090); inv = 0;
        rd(8'h08, 32'h3000_02D0);
        sts_l = 1; cyc(5); sts_l = 0; cyc(5);
        `CHK(sts_n, 4)
        ident(7'h01);
        rd(8'h08, 32'h3000_02C0);
        ident(7'h14);
        rd(8'h08, 32'h3000_0A60);
    endtask : t_narrow
    task close_out;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out
    // Whole run is under a hundred cycles; this span is ample
    initial begin
        #50us;
        failures++;
        close_out();
    end
    initial begin
        {resetn, gr, pr, pme, rd_en, fw, busy, done, pack, pon} = '0;
        {inv, loss, present, sts_l, rdy_l} = '0;
        addr = 8'h00; cfg = 8'h00; fd = 32'h0; res = '0;
        cyc(2); resetn = 1;
        t_reset();
        t_insert();
        t_pins();
        t_force();
        t_context();
        t_narrow();
        close_out();
    end
endmodule : spss_status_tb
